// >>> rtl/pct_pkg.sv
// package: register map, field positions, reset values and timing for the timer
package pct_pkg;

  // register byte offsets
  localparam logic [7:0] PCT_OFF_CONFIG = 8'h00;
  localparam logic [7:0] PCT_OFF_VALUE = 8'h04;
  localparam logic [7:0] PCT_OFF_STATUS = 8'h08;
  localparam logic [7:0] PCT_OFF_ENABLE = 8'h0c;
  localparam logic [7:0] PCT_OFF_CLEAR = 8'h10;

  // countdown_config fields
  localparam int PCT_CFG_LOAD_LSB = 0;
  localparam int PCT_CFG_LOAD_W = 16;
  localparam int PCT_CFG_RUN_BIT = 29;

  // irq status / enable / clear layout
  localparam int PCT_IRQ_EXPIRED_BIT = 0;

  // reset values
  localparam logic [15:0] PCT_LOAD_RST = 16'hffff;
  localparam logic [15:0] PCT_COUNT_RST = 16'hffff;
  localparam logic [15:0] PCT_COUNT_ZERO = 16'h0000;

  // timing
  localparam int PCT_CLK_HZ = 40000000;
  localparam int PCT_TICK_US = 100;
  localparam int PCT_TICK_CYCLES = (PCT_CLK_HZ / 1000000) * PCT_TICK_US;

  // decoded register access from the bus slave
  typedef struct packed {
    logic wr_config;
    logic wr_enable;
    logic wr_clear;
    logic [31:0] wdata;
  } pct_wr_s;

endpackage : pct_pkg

// >>> rtl/pct_prescaler.sv
// tick prescaler: one-cycle pulse every period cycles while running
`timescale 1ns/10ps
module pct_prescaler
  import pct_pkg::*;
#(
  parameter int PERIOD = PCT_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  // tick output
  output logic tick
);

  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  wire at_last = (cnt_reg == LAST);

  // restart realigns the tick grid so the first decrement is a full tick away
  assign cnt_next = (!run || restart || at_last) ? '0 : cnt_reg + 1'b1;
  assign tick = run && !restart && at_last; // [RULE1]

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule : pct_prescaler

// >>> rtl/pct_apb_slave.sv
// apb slave: address decode, zero wait states, read mux, error on unmapped
`timescale 1ns/10ps
module pct_apb_slave
  import pct_pkg::*;
(
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register side
  input wire logic [31:0] rd_config,
  input wire logic [31:0] rd_value,
  input wire logic [31:0] rd_status,
  input wire logic [31:0] rd_enable,
  output pct_wr_s wr
);

  wire access = psel && penable;
  wire hit_cfg = (paddr == PCT_OFF_CONFIG);
  wire hit_val = (paddr == PCT_OFF_VALUE);
  wire hit_sts = (paddr == PCT_OFF_STATUS);
  wire hit_en = (paddr == PCT_OFF_ENABLE);
  wire hit_clr = (paddr == PCT_OFF_CLEAR);
  wire mapped = hit_cfg | hit_val | hit_sts | hit_en | hit_clr;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // clear register is write-only and reads as zero
  assign prdata = hit_cfg ? rd_config :
                  hit_val ? rd_value :
                  hit_sts ? rd_status :
                  hit_en ? rd_enable : 32'h0000_0000;

  assign wr.wr_config = access && pwrite && hit_cfg;
  assign wr.wr_enable = access && pwrite && hit_en;
  assign wr.wr_clear = access && pwrite && hit_clr;
  assign wr.wdata = pwdata;

endmodule : pct_apb_slave

// >>> rtl/pct_timer.sv
// periodic countdown timer with apb registers and level interrupt
`timescale 1ns/10ps
// What this block does
// [RULE1] The count drops by one on each 100 us tick made from the clock.
// [RULE2] Setting the run bit loads the preload into the count and starts it.
// [RULE3] Reset and a run bit fall from one to zero force preload to ffff.
// [RULE4] Reset sets the count to ffff.
// [RULE5] Software may write the preload at any time, running or not.
// [RULE6] Running, the count goes down to zero; a new preload restarts it.
// [RULE7] At zero the count wraps to ffff, flags expiry and keeps going.
// [RULE8] The expiry flag and the interrupt line need the irq mask bit set.
// [RULE9] The expiry flag is sticky and cleared only by writing a one.
// [RULE10] With the run bit clear the count holds and no interrupt is made.
// [RULE11] Writing a zero to the expiry flag position changes nothing.
module pct_timer
  import pct_pkg::*;
#(
  parameter int TICK_CYCLES = PCT_TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);

  pct_wr_s wr;
  logic [15:0] load_reg;
  logic [15:0] load_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic run_reg;
  logic run_next;
  logic mask_reg;
  logic mask_next;
  logic flag_reg;
  logic flag_next;
  logic tick;

  wire [15:0] wr_load = wr.wdata[PCT_CFG_LOAD_LSB +: PCT_CFG_LOAD_W];
  wire wr_run = wr.wdata[PCT_CFG_RUN_BIT];
  wire run_rise = wr.wr_config && wr_run && !run_reg;
  wire run_fall = wr.wr_config && !wr_run && run_reg;
  wire load_write = wr.wr_config && wr_run && run_reg && (wr_load != load_reg);
  wire restart = run_rise || load_write;
  wire at_zero = (count_reg == PCT_COUNT_ZERO);
  wire expire = run_reg && tick && at_zero;
  wire clr_hit = wr.wr_clear && wr.wdata[PCT_IRQ_EXPIRED_BIT];

  pct_apb_slave u_bus (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rd_config({2'b00, run_reg, 13'h0000, load_reg}),
    .rd_value({16'h0000, count_reg}),
    .rd_status({31'h0000_0000, flag_reg}),
    .rd_enable({31'h0000_0000, mask_reg}),
    .wr(wr)
  );

  pct_prescaler #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(run_reg),
    .restart(restart),
    .tick(tick)
  );

  // a run fall wins over any preload in the same write
  assign load_next = run_fall ? PCT_LOAD_RST : // [RULE3]
                     wr.wr_config ? wr_load : load_reg; // [RULE5]
  assign run_next = wr.wr_config ? wr_run : run_reg;
  assign mask_next = wr.wr_enable ? wr.wdata[PCT_IRQ_EXPIRED_BIT] : mask_reg;

  // restart uses the value being written, not the stale preload
  assign count_next = restart ? wr_load : // [RULE2] [RULE6]
                      !run_reg ? count_reg : // [RULE10]
                      !tick ? count_reg :
                      at_zero ? PCT_COUNT_RST : // [RULE7]
                      count_reg - 16'h0001; // [RULE1] [RULE6]

  // set wins over a clear in the same cycle; zero writes are ignored
  assign flag_next = (expire && mask_reg) ? 1'b1 : // [RULE7] [RULE8]
                     clr_hit ? 1'b0 : flag_reg; // [RULE9] [RULE11]

  assign irq = flag_reg && mask_reg; // [RULE8]

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      load_reg <= PCT_LOAD_RST; // [RULE3]
      count_reg <= PCT_COUNT_RST; // [RULE4]
      run_reg <= 1'b0;
      mask_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      load_reg <= load_next;
      count_reg <= count_next;
      run_reg <= run_next;
      mask_reg <= mask_next;
      flag_reg <= flag_next;
    end
  end

endmodule : pct_timer

// >>> bench/pct_timer_props.sv
// checker: bus answer and interrupt properties of the timer
`timescale 1ns/10ps
module pct_timer_chk
  import pct_pkg::*;
#(parameter int TICK_CYCLES = PCT_TICK_CYCLES)
(
  // clock, reset, apb and interrupt
  input wire logic clk_sys, rst, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, irq
);
  wire acc = psel & penable;
  wire rd = acc & !pwrite;
  wire wr = acc & pwrite;
  logic run_reg;
  // run is tracked from writes, the config register is not visible here
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) run_reg <= 1'b0;
    else if (wr && paddr == PCT_OFF_CONFIG) run_reg <= pwdata[PCT_CFG_RUN_BIT];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_map; acc && (paddr > PCT_OFF_CLEAR || paddr[1:0] == 2'h0)
    |-> pslverr == (paddr > PCT_OFF_CLEAR); endproperty
  a_map: assert property (p_map) else $error("bad slverr");
  // run bit read back must follow the last accepted config write
  property p_cfg; rd && paddr == PCT_OFF_CONFIG |-> prdata[31:16] ==
    {2'b00, run_reg, 13'h0}; endproperty
  a_cfg: assert property (p_cfg) else $error("config bits");
  property p_val; rd && paddr == PCT_OFF_VALUE |-> prdata[31:16] == 16'h0;
  endproperty
  a_val: assert property (p_val) else $error("value bits");
  property p_sts; rd && paddr == PCT_OFF_STATUS
    |-> prdata[31:1] == 31'h0 && (prdata[0] || !irq); endproperty
  a_sts: assert property (p_sts) else $error("status");
  property p_clr; rd && paddr == PCT_OFF_CLEAR |-> prdata == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear read");
  property p_fall; $fell(irq) |-> $past(wr && (paddr == PCT_OFF_CLEAR &&
    pwdata[0] || paddr == PCT_OFF_ENABLE && !pwdata[0])); endproperty
  a_fall: assert property (p_fall) else $error("irq fell");
  property p_rise; $rose(irq) |-> run_reg || $past(run_reg) ||
    $past(wr && paddr == PCT_OFF_ENABLE); endproperty
  a_rise: assert property (p_rise) else $error("irq rose");
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && pslverr);
  c_clr: cover property (wr && paddr == PCT_OFF_CLEAR && pwdata[0]);
endmodule : pct_timer_chk
bind pct_timer pct_timer_chk #(.TICK_CYCLES(TICK_CYCLES)) pct_timer_chk_i (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

// >>> bench/tb_top.sv
// testbench: registers, countdown and interrupt of the timer
`timescale 1ns/10ps
module tb_top
  import pct_pkg::*;
;
  localparam int T = 4;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int failures = 0, checks = 0;
  // write, address, data or expected read, expected error
  logic [41:0] rows [5] = '{{1'b0, PCT_OFF_CONFIG, 32'hffff, 1'b0},
    {1'b0, PCT_OFF_VALUE, 32'hffff, 1'b0}, {1'b0, 8'h14, 32'h0, 1'b1},
    {1'b1, PCT_OFF_CONFIG, 32'h1234, 1'b0},
    {1'b0, PCT_OFF_CONFIG, 32'h1234, 1'b0}};
  pct_timer #(.TICK_CYCLES(T)) pct_timer_i (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
  initial
    forever #12.5 clk_sys = ~clk_sys;
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // the tests need only about a hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      apb(rows[i][41], rows[i][40:33], rows[i][32:1]);
      if (!rows[i][41] && !rows[i][0])
        chk("rdata", rows[i][32:1], rd);
      chk("slverr", {31'h0, rows[i][0]}, {31'h0, er});
    end
    apb(1'b1, PCT_OFF_ENABLE, 32'h1);
    apb(1'b1, PCT_OFF_CONFIG, 32'h2000_0002);
    apb(1'b0, PCT_OFF_VALUE, 32'h0);
    chk("value", 32'h2, rd);
    // third tick lands 3*T edges after the write; irq is looked at mid-cycle
    repeat (2 * T) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    @(negedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, PCT_OFF_VALUE, 32'h0);
    chk("value", 32'hffff, rd);
    apb(1'b1, PCT_OFF_CLEAR, 32'h0);
    @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, PCT_OFF_CLEAR, 32'h1);
    @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, PCT_OFF_CONFIG, 32'h2000_0005);
    apb(1'b0, PCT_OFF_VALUE, 32'h0);
    chk("value", 32'h5, rd);
    apb(1'b1, PCT_OFF_CONFIG, 32'h5);
    apb(1'b0, PCT_OFF_CONFIG, 32'h0);
    chk("config", 32'hffff, rd);
    // one tick passed before the stop, later ticks would drop it further
    apb(1'b0, PCT_OFF_VALUE, 32'h0);
    chk("value", 32'h4, rd);
    apb(1'b1, PCT_OFF_ENABLE, 32'h0);
    apb(1'b1, PCT_OFF_CONFIG, 32'h2000_0000);
    repeat (3 * T) @(posedge clk_sys);
    apb(1'b0, PCT_OFF_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    // reset in mid-run, with preload 0 and a moving count
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, PCT_OFF_CONFIG, 32'h0);
    chk("config", 32'hffff, rd);
    apb(1'b0, PCT_OFF_VALUE, 32'h0);
    chk("value", 32'hffff, rd);
    print_verdict();
  end
endmodule : tb_top
